//--- sdci_assertions.sv
// Concurrent checks on the link between the controller end and the device end.
// Assumes one clock and an active-low async reset shared by both ends.
`timescale 1ns/1ps
module sdci_assertions
  import sdci_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic clk_gate,
  input wire logic [SDCI_ROW_W-1:0] addr_bus,
  input wire logic [SDCI_DATA_W/8-1:0] byte_mask,
  input wire logic [SDCI_DATA_W-1:0] dq_rd,
  input wire logic [SDCI_DATA_W/8-1:0] dq_rd_oe
);
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  logic gq;
  logic [2:0] bl;
  logic [2:0] lat;
  logic [4:0] quiet;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of the gate and of the mode fields
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gq <= 1'b1;
      bl <= SDCI_MODE_RST[2:0];
      lat <= SDCI_MODE_RST[6:4];
    end else begin
      gq <= clk_gate;
      if (gq && cmd == SDCI_CMD_MODE) begin
        bl <= addr_bus[2:0];
        lat <= addr_bus[6:4];
      end
    end
  end
  // Taken cycles since the last read, saturating
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quiet <= 5'h1f;
    end else if (gq && cmd == SDCI_CMD_READ) begin
      quiet <= 5'h0;
    end else if (gq && quiet != 5'h1f) begin
      quiet <= quiet + 5'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property ($rose(nrst_in) |-> cs_n && clk_gate)
    else $error("link not idle after reset");
  a_read_lat_two: assert property ((cmd == SDCI_CMD_READ && gq && lat == SDCI_CL_2 &&
    byte_mask == 4'h0) |-> ##[2:4] (dq_rd_oe != 4'h0))
    else $error("no read data at latency two");
  a_read_lat_three: assert property ((cmd == SDCI_CMD_READ && gq && lat == SDCI_CL_3 &&
    byte_mask == 4'h0) |-> ##3 (dq_rd_oe == 4'h0) ##[1:2] (dq_rd_oe != 4'h0))
    else $error("read data timing wrong at latency three");
  a_mask_read_gap: assert property ((gq && clk_gate && byte_mask != 4'h0) |=>
    ##1 ((dq_rd_oe & $past(byte_mask, 2)) == 4'h0))
    else $error("masked byte driven two cycles later");
  a_freeze_output: assert property (($past(clk_gate, 2) == 1'b0 && $past(nrst_in, 2) &&
    $past(nrst_in)) |-> ($stable(dq_rd) && $stable(dq_rd_oe)))
    else $error("output moved while clock suspended");
  a_quiet_no_oe: assert property ((quiet > 5'd13 && bl != SDCI_BL_PAGE) |->
    dq_rd_oe == 4'h0)
    else $error("read data outside any burst");
  a_stop_ends: assert property ((cmd == SDCI_CMD_STOP && gq) |->
    ##[4:8] (dq_rd_oe == 4'h0))
    else $error("burst not ended by stop");
  a_single_beat: assert property ((cmd == SDCI_CMD_READ && gq && bl == SDCI_BL_1 &&
    byte_mask == 4'h0) |-> ##[2:5] (dq_rd_oe != 4'h0 && $past(dq_rd_oe) == 4'h0)
    ##1 (dq_rd_oe == 4'h0))
    else $error("single burst gave more than one beat");
  c_read: cover property (cmd == SDCI_CMD_READ && gq);
  c_stop: cover property (cmd == SDCI_CMD_STOP && gq);
  c_suspend: cover property (!clk_gate && gq);
endmodule // sdci_assertions

//--- sdci_ctl.sv
// Memory controller end: turns user requests into link commands.
// Assumes the device end shares clk_in; requests are one-cycle pulses.
`timescale 1ns/1ps
module sdci_ctl
  import sdci_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link
  sdci_if.ctl link,
  // User requests
  input wire logic req_valid_in,
  input wire logic [2:0] req_op_in,
  input wire logic [1:0] req_bank_in,
  input wire logic [SDCI_ROW_W-1:0] req_addr_in,
  input wire logic req_ap_in,
  input wire logic [SDCI_DATA_W-1:0] req_wdata_in,
  input wire logic [SDCI_DATA_W/8-1:0] req_mask_in,
  // Status
  output logic req_refused_out,
  output logic [SDCI_BANKS-1:0] open_banks_out,
  output logic [SDCI_DATA_W-1:0] rd_data_out,
  output logic rd_valid_out
);

  logic [SDCI_BANKS-1:0] open_q;
  logic ok;

  always_comb begin
    case (req_op_in)
      SDCI_REQ_READ, SDCI_REQ_WRITE: ok = open_q[req_bank_in]; // see RL22
      SDCI_REQ_OPEN: ok = !open_q[req_bank_in];
      SDCI_REQ_MODE, SDCI_REQ_SLEEP: ok = (open_q == '0); // see RL4
      default: ok = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Command drive, aligned to the clock edge

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCI_CMD_DESEL;
      link.clk_gate <= 1'b1;
      link.bank_sel_lo <= 1'b0;
      link.bank_sel_hi <= 1'b0;
      link.addr_bus <= '0;
      link.byte_mask <= '0;
      link.dq_wr <= '0;
      req_refused_out <= 1'b0;
    end else begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCI_CMD_NOP; // see RL1
      link.byte_mask <= req_mask_in; // see RL21
      link.dq_wr <= req_wdata_in;
      req_refused_out <= req_valid_in && !ok;
      if (req_valid_in && ok) begin
        {link.bank_sel_hi, link.bank_sel_lo} <= req_bank_in; // see RL6
        link.addr_bus <= req_addr_in; // see RL8 RL11
        case (req_op_in)
          SDCI_REQ_OPEN: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCI_CMD_ROW_OPEN;
          SDCI_REQ_READ, SDCI_REQ_WRITE: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <=
              (req_op_in == SDCI_REQ_READ) ? SDCI_CMD_READ : SDCI_CMD_WRITE; // see RL15 RL20
            link.addr_bus[SDCI_AP_BIT] <= req_ap_in; // see RL9
          end
          SDCI_REQ_CLOSE: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCI_CMD_CLOSE;
          SDCI_REQ_MODE: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCI_CMD_MODE;
            link.bank_sel_lo <= req_bank_in[0]; // see RL7
          end
          SDCI_REQ_STOP: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCI_CMD_STOP;
          SDCI_REQ_SLEEP: link.clk_gate <= 1'b0; // see RL4
          SDCI_REQ_WAKE: link.clk_gate <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bank tracking and read capture

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      open_q <= '0;
      open_banks_out <= '0;
    end else begin
      if (req_valid_in && ok) begin
        case (req_op_in)
          SDCI_REQ_OPEN: open_q[req_bank_in] <= 1'b1; // see RL22
          SDCI_REQ_CLOSE: begin
            if (req_addr_in[SDCI_AP_BIT]) begin
              open_q <= '0;
            end else begin
              open_q[req_bank_in] <= 1'b0;
            end
          end
          SDCI_REQ_READ, SDCI_REQ_WRITE: begin
            if (req_ap_in) begin
              open_q[req_bank_in] <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      open_banks_out <= open_q;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= |link.dq_rd_oe;
      rd_data_out <= link.dq_rd;
    end
  end

endmodule // sdci_ctl

//--- sdci_dev.sv
// SDRAM command decoder, bank state, burst counter and read pipeline.
// Assumes inputs are synchronous to clk_in; storage is outside (user port).
//
// Functional notes
// RL1: All inputs sampled on rising clock edge.
// RL2: Burst counter advances while clock enabled.
// RL3: Gate low freezes outputs and burst next cycle.
// RL4: Low-power entry only with all banks idle.
// RL5: Low-power mode ignores all inputs except gate.
// RL6: Bank select picks the command's target bank.
// RL7: Bank select gives mode word bit eleven.
// RL8: Row open captures eleven-bit row address.
// RL9: Column from low bits; bit ten auto-precharge.
// RL10: Precharge with bit ten closes all banks.
// RL11: Address bus carries mode operation code.
// RL12: Chip select high masks all commands.
// RL13: Row-open code activates the addressed bank.
// RL14: Close code returns the bank to idle.
// RL15: Access is row open then read/write burst.
// RL16: Burst lengths 1,2,4,8,page; early stop.
// RL17: Auto precharge closes row at burst end.
// RL18: Read latency two or three cycles.
// RL19: Interleaved or sequential burst addresses.
// RL20: Column strobe starts read or write.
// RL21: Byte mask blocks writes, reads two later.
// RL22: Controller only accesses opened banks.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module sdci_dev
  import sdci_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link
  sdci_if.dev link,
  // Storage side
  output logic mem_we_out,
  output logic [SDCI_DATA_W/8-1:0] mem_be_out,
  output logic [1:0] mem_bank_out,
  output logic [SDCI_ROW_W-1:0] mem_row_out,
  output logic [SDCI_COL_W-1:0] mem_col_out,
  output logic [SDCI_DATA_W-1:0] mem_wdata_out,
  input wire logic [SDCI_DATA_W-1:0] mem_rdata_in,
  // Status
  output logic [SDCI_BANKS-1:0] bank_active_out,
  output logic low_power_out,
  output logic [SDCI_MODE_W-1:0] mode_out
);

  localparam int PIPE = 3;
  localparam int MW = SDCI_DATA_W / 8;

  logic gate_q;
  logic run;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [SDCI_ROW_W-1:0] row [SDCI_BANKS];
  logic [SDCI_MODE_W-1:0] mode;
  logic burst_on;
  logic burst_wr;
  logic burst_ap;
  logic [1:0] burst_bank;
  logic [SDCI_COL_W-1:0] burst_base;
  logic [SDCI_COL_W-1:0] burst_cnt;
  logic [SDCI_COL_W-1:0] burst_last;
  logic [SDCI_COL_W-1:0] col_now;
  logic [SDCI_COL_W-1:0] len_mask;
  logic burst_end;
  logic [PIPE-1:0] rd_pipe;
  logic [SDCI_DATA_W-1:0] rd_data [PIPE-1];
  logic [MW-1:0] mask_d1;
  logic [SDCI_DATA_W-1:0] wdata_d1;
  logic [2:0] cl;

  //////////////////////////////////////////////////////////////////////////
  // Command decode

  // Clock runs in a cycle only when the gate was high the edge before
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_q <= 1'b1;
    end else begin
      gate_q <= link.clk_gate; // see RL3
    end
  end

  assign run = gate_q && !low_power_out; // see RL5
  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n}; // see RL1 RL12
  assign bank = {link.bank_sel_hi, link.bank_sel_lo}; // see RL6
  assign cl = mode[SDCI_MODE_CL_LSB +: 3];

  always_comb begin
    case (mode[SDCI_MODE_BL_LSB +: 3])
      SDCI_BL_1: len_mask = 8'h00;
      SDCI_BL_2: len_mask = 8'h01;
      SDCI_BL_4: len_mask = 8'h03;
      SDCI_BL_8: len_mask = 8'h07;
      default: len_mask = 8'hff;
    endcase
  end

  // Offset within the wrap window, sequential adds and interleaved xors
  always_comb begin
    if (mode[SDCI_MODE_BT_BIT]) begin
      col_now = (burst_base & ~len_mask) | ((burst_base ^ burst_cnt) & len_mask); // see RL19
    end else begin
      col_now = (burst_base & ~len_mask) | ((burst_base + burst_cnt) & len_mask); // see RL19
    end
  end

  assign burst_end = burst_on && (burst_cnt == burst_last);

  //////////////////////////////////////////////////////////////////////////
  // Mode register and low power

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= SDCI_MODE_RST;
    end else if (run && cmd == SDCI_CMD_MODE && bank_active_out == '0) begin
      mode <= {link.bank_sel_lo, link.addr_bus}; // see RL7 RL11
    end
  end

  // Entered with gate falling on an idle device; gate acts level-only inside
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_power_out <= 1'b0;
    end else if (low_power_out) begin
      low_power_out <= !link.clk_gate; // see RL5
    end else if (gate_q && !link.clk_gate && bank_active_out == '0 && !burst_on) begin
      low_power_out <= 1'b1; // see RL4
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bank state

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_active_out <= '0;
      for (int i = 0; i < SDCI_BANKS; i++) begin
        row[i] <= '0;
      end
    end else if (run) begin
      if (cmd == SDCI_CMD_ROW_OPEN) begin
        bank_active_out[bank] <= 1'b1; // see RL13 RL6
        row[bank] <= link.addr_bus; // see RL8
      end else if (cmd == SDCI_CMD_CLOSE) begin
        if (link.addr_bus[SDCI_AP_BIT]) begin
          bank_active_out <= '0; // see RL10
        end else begin
          bank_active_out[bank] <= 1'b0; // see RL14
        end
      end
      if (burst_end && burst_ap) begin
        bank_active_out[burst_bank] <= 1'b0; // see RL17
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Burst engine

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      burst_on <= 1'b0;
      burst_wr <= 1'b0;
      burst_ap <= 1'b0;
      burst_bank <= '0;
      burst_base <= '0;
      burst_cnt <= '0;
      burst_last <= '0;
    end else if (run) begin
      if ((cmd == SDCI_CMD_READ || cmd == SDCI_CMD_WRITE) && bank_active_out[bank]) begin
        burst_on <= 1'b1; // see RL15 RL20
        burst_wr <= !link.we_n; // see RL20
        burst_ap <= link.addr_bus[SDCI_AP_BIT]; // see RL9
        burst_bank <= bank;
        burst_base <= link.addr_bus[SDCI_COL_W-1:0]; // see RL9
        burst_cnt <= '0;
        burst_last <= len_mask; // see RL16
      end else if (cmd == SDCI_CMD_STOP || cmd == SDCI_CMD_CLOSE || burst_end) begin
        burst_on <= 1'b0; // see RL16
      end else if (burst_on) begin
        burst_cnt <= burst_cnt + 8'h01; // see RL2
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage access and read pipeline

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_we_out <= 1'b0;
      mem_be_out <= '0;
      mem_bank_out <= '0;
      mem_row_out <= '0;
      mem_col_out <= '0;
      mem_wdata_out <= '0;
    end else begin
      mem_we_out <= run && burst_on && burst_wr && !(cmd == SDCI_CMD_STOP);
      mem_be_out <= ~mask_d1; // see RL21
      mem_bank_out <= burst_bank;
      mem_row_out <= row[burst_bank];
      mem_col_out <= col_now;
      mem_wdata_out <= wdata_d1;
    end
  end

  // Read data arrives one cycle after the address; latency set by the tap
  // Write data and mask are held one cycle so each beat gets its own word
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_pipe <= '0;
      mask_d1 <= '0;
      wdata_d1 <= '0;
      for (int i = 0; i < PIPE - 1; i++) begin
        rd_data[i] <= '0;
      end
    end else if (run) begin // see RL3
      rd_pipe <= {rd_pipe[PIPE-2:0], burst_on && !burst_wr && cmd != SDCI_CMD_STOP};
      rd_data[0] <= mem_rdata_in;
      for (int i = 1; i < PIPE - 1; i++) begin
        rd_data[i] <= rd_data[i-1];
      end
      mask_d1 <= link.byte_mask; // see RL21
      wdata_d1 <= link.dq_wr;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.dq_rd <= '0;
      link.dq_rd_oe <= '0;
    end else if (run) begin // see RL2 RL3
      if (cl == SDCI_CL_2) begin
        link.dq_rd <= rd_data[0];
        link.dq_rd_oe <= {MW{rd_pipe[1]}} & ~mask_d1; // see RL18 RL21
      end else begin
        link.dq_rd <= rd_data[1];
        link.dq_rd_oe <= {MW{rd_pipe[2]}} & ~mask_d1; // see RL18 RL21
      end
    end else if (low_power_out) begin
      link.dq_rd_oe <= '0;
    end
  end

  assign mode_out = mode;

endmodule // sdci_dev

//--- sdci_if.sv
// Interface joining the memory controller and the SDRAM command front end.
// Assumes one shared clock; write and read data use separate dq_wr and dq_rd lines.
`timescale 1ns/1ps
interface sdci_if;
  import sdci_pkg::*;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic clk_gate;
  logic bank_sel_lo;
  logic bank_sel_hi;
  logic [SDCI_ROW_W-1:0] addr_bus;
  logic [SDCI_DATA_W/8-1:0] byte_mask;
  logic [SDCI_DATA_W-1:0] dq_wr;
  logic [SDCI_DATA_W-1:0] dq_rd;
  logic [SDCI_DATA_W/8-1:0] dq_rd_oe;
  modport dev (
    input cs_n, ras_n, cas_n, we_n, clk_gate, bank_sel_lo, bank_sel_hi,
    input addr_bus, byte_mask, dq_wr,
    output dq_rd, dq_rd_oe
  );
  modport ctl (
    output cs_n, ras_n, cas_n, we_n, clk_gate, bank_sel_lo, bank_sel_hi,
    output addr_bus, byte_mask, dq_wr,
    input dq_rd, dq_rd_oe
  );
endinterface

//--- sdci_pkg.sv
// Package for the SDRAM command interface: command codes, widths, mode fields.
// Assumes both ends are clocked by the same clk_in.
package sdci_pkg;
  localparam int SDCI_ROW_W = 11;
  localparam int SDCI_COL_W = 8;
  localparam int SDCI_BANKS = 4;
  localparam int SDCI_DATA_W = 32;
  localparam int SDCI_AP_BIT = 10;
  localparam int SDCI_MASK_LAT = 2;
  // Mode word fields (bit 11 comes from bank select)
  localparam int SDCI_MODE_W = 12;
  localparam int SDCI_MODE_BL_LSB = 0;
  localparam int SDCI_MODE_BT_BIT = 3;
  localparam int SDCI_MODE_CL_LSB = 4;
  localparam logic [SDCI_MODE_W-1:0] SDCI_MODE_RST = 12'h022;
  // Burst length and read latency codes
  localparam logic [2:0] SDCI_BL_1 = 3'h0;
  localparam logic [2:0] SDCI_BL_2 = 3'h1;
  localparam logic [2:0] SDCI_BL_4 = 3'h2;
  localparam logic [2:0] SDCI_BL_8 = 3'h3;
  localparam logic [2:0] SDCI_BL_PAGE = 3'h7;
  localparam logic [2:0] SDCI_CL_2 = 3'h2;
  localparam logic [2:0] SDCI_CL_3 = 3'h3;
  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDCI_CMD_ROW_OPEN = 4'h3,
    SDCI_CMD_CLOSE = 4'h2,
    SDCI_CMD_READ = 4'h5,
    SDCI_CMD_WRITE = 4'h4,
    SDCI_CMD_MODE = 4'h0,
    SDCI_CMD_REFRESH = 4'h1,
    SDCI_CMD_STOP = 4'h6,
    SDCI_CMD_NOP = 4'h7,
    SDCI_CMD_DESEL = 4'h8
  } sdci_cmd_t;
  // Host request opcodes
  typedef enum logic [2:0] {
    SDCI_REQ_OPEN = 3'h0,
    SDCI_REQ_READ = 3'h1,
    SDCI_REQ_WRITE = 3'h2,
    SDCI_REQ_CLOSE = 3'h3,
    SDCI_REQ_MODE = 3'h4,
    SDCI_REQ_STOP = 3'h5,
    SDCI_REQ_SLEEP = 3'h6,
    SDCI_REQ_WAKE = 3'h7
  } sdci_req_t;
endpackage

//--- test_sdram_command_interface.sv
// Testbench: controller and device ends joined by the link, storage model on the device.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
module test_sdram_command_interface;
  import sdci_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [1:0] req_bank = 2'h0;
  logic [10:0] req_addr = 11'h0;
  logic req_ap = 1'b0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_mask = 4'h0;
  logic req_refused, rd_valid, mem_we, low_power, quiet, refd;
  logic [3:0] open_banks, mem_be, bank_active;
  logic [1:0] mem_bank;
  logic [10:0] mem_row, row;
  logic [7:0] mem_col, col;
  logic [11:0] mode;
  logic [31:0] rd_data, mem_wdata, mem_rdata, d1;
  logic [31:0] d [4];
  logic [31:0] mem [0:4095];
  logic [31:0] exp_rd [$];
  logic [20:0] exp_wr [$];
  int miscompares, n_tests, n_rd, n0, n;
  sdci_if link();
  sdci_dev i_sdci_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(link), .mem_we_out(mem_we),
    .mem_be_out(mem_be), .mem_bank_out(mem_bank), .mem_row_out(mem_row),
    .mem_col_out(mem_col), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
    .bank_active_out(bank_active), .low_power_out(low_power), .mode_out(mode));
  sdci_ctl i_sdci_ctl (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_bank_in(req_bank),
    .req_addr_in(req_addr), .req_ap_in(req_ap), .req_wdata_in(req_wdata),
    .req_mask_in(req_mask), .req_refused_out(req_refused), .open_banks_out(open_banks),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid));
  sdci_assertions i_sdci_assertions (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .clk_gate(link.clk_gate),
    .addr_bus(link.addr_bus), .byte_mask(link.byte_mask), .dq_rd(link.dq_rd),
    .dq_rd_oe(link.dq_rd_oe));
  always #5 clk_in = ~clk_in;
  assign mem_rdata = mem[{mem_bank, mem_row[1:0], mem_col}];
  //////////////////////////////////////////////////////////////////////////////
  task automatic note(input string m);
    miscompares++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) note($sformatf("got %h expected %h", got, exp));
  endtask
  task automatic chk_loc(input logic [20:0] got, input logic [20:0] exp);
    n_tests++;
    if (got !== exp) note($sformatf("beat at %h expected %h", got, exp));
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // One request pulse, then two idle edges so status has settled
  task automatic req(input logic [2:0] op, input logic [1:0] bk, input logic [10:0] a,
      input logic ap, input logic [3:0] mk);
    req_op <= op;
    req_bank <= bk;
    req_addr <= a;
    req_ap <= ap;
    req_mask <= mk;
    req_valid <= 1'b1;
    @(posedge clk_in);
    req_valid <= 1'b0;
    req_mask <= 4'h0;
    @(negedge clk_in);
    refd = req_refused;
    @(posedge clk_in);
    @(posedge clk_in);
  endtask
  function automatic logic [7:0] bcol(input logic [7:0] c, input int w, input int i,
      input logic il);
    logic [7:0] m;
    m = 8'(w - 1);
    if (il) return c ^ 8'(i);
    return (c & ~m) | ((c + 8'(i)) & m);
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (n_tests > 0 && miscompares == 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Storage model and result monitor
  always @(posedge clk_in) begin
    if (mem_we === 1'b1) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_be[b]) mem[{mem_bank, mem_row[1:0], mem_col}][8*b +: 8] = mem_wdata[8*b +: 8];
      end
      if (exp_wr.size() == 0) note("unexpected write beat");
      else chk_loc({mem_bank, mem_row, mem_col}, exp_wr.pop_front());
    end
    if (rd_valid === 1'b1) begin
      n_rd++;
      if (!quiet && exp_rd.size() == 0) note("unexpected read beat");
      else if (!quiet) chk_data(rd_data, exp_rd.pop_front());
    end
  end
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    quiet = 1'b0;
    void'($urandom(32'hbb0b));
    row = 11'($urandom);
    col = 8'($urandom);
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    req(SDCI_REQ_MODE, 2'h1, {4'h0, SDCI_CL_2, 1'b0, SDCI_BL_1}, 1'b0, 4'h0);
    chk_data(32'(mode), 32'h820);
    for (int b = 0; b < 4; b++) begin
      req(SDCI_REQ_OPEN, 2'(b), row, 1'b0, 4'h0);
      chk_data(32'(bank_active), 32'(4'hf >> (3 - b)));
      chk_data(32'(open_banks), 32'(4'hf >> (3 - b)));
      d[b] = $urandom;
      req_wdata <= d[b];
      exp_wr.push_back({2'(b), row, col});
      req(SDCI_REQ_WRITE, 2'(b), {3'h0, col}, 1'b0, 4'h0);
      exp_rd.push_back(d[b]);
      req(SDCI_REQ_READ, 2'(b), {3'h0, col}, 1'b0, 4'h0);
      wait_n(6);
    end
    req(SDCI_REQ_CLOSE, 2'h2, 11'h0, 1'b0, 4'h0);
    chk_data(32'(bank_active), 32'hb);
    req(SDCI_REQ_READ, 2'h2, {3'h0, col}, 1'b0, 4'h0);
    chk_data(32'(refd), 32'h1);
    d1 = $urandom;
    req_wdata <= d1;
    exp_wr.push_back({2'h0, row, col});
    req(SDCI_REQ_WRITE, 2'h0, {3'h0, col}, 1'b0, 4'h3);
    exp_rd.push_back({d1[31:16], d[0][15:0]});
    req(SDCI_REQ_READ, 2'h0, {3'h0, col}, 1'b0, 4'h0);
    wait_n(6);
    req(SDCI_REQ_CLOSE, 2'h0, 11'h400, 1'b0, 4'h0);
    chk_data(32'(bank_active), 32'h0);
    req(SDCI_REQ_MODE, 2'h0, {4'h0, SDCI_CL_3, 1'b0, SDCI_BL_1}, 1'b0, 4'h0);
    req(SDCI_REQ_OPEN, 2'h1, row, 1'b0, 4'h0);
    exp_rd.push_back(d[1]);
    req(SDCI_REQ_READ, 2'h1, {3'h0, col}, 1'b0, 4'h0);
    wait_n(8);
    req(SDCI_REQ_CLOSE, 2'h0, 11'h400, 1'b0, 4'h0);
    for (int k = 0; k < 2; k++) begin
      n = k ? 8 : 4;
      req(SDCI_REQ_MODE, 2'h0, {4'h0, SDCI_CL_2, k[0], k ? SDCI_BL_8 : SDCI_BL_4}, 1'b0, 4'h0);
      req(SDCI_REQ_OPEN, 2'h3, row, 1'b0, 4'h0);
      for (int i = 0; i < n; i++) exp_wr.push_back({2'h3, row, bcol(col, n, i, k[0])});
      req(SDCI_REQ_WRITE, 2'h3, {3'h0, col}, k[0], 4'h0);
      wait_n(12);
      chk_data(32'(bank_active), k ? 32'h0 : 32'h8);
      req(SDCI_REQ_CLOSE, 2'h0, 11'h400, 1'b0, 4'h0);
    end
    req(SDCI_REQ_OPEN, 2'h1, row, 1'b0, 4'h0);
    quiet = 1'b1;
    n0 = n_rd;
    req(SDCI_REQ_READ, 2'h1, {3'h0, col}, 1'b0, 4'h0);
    wait_n(3);
    req(SDCI_REQ_STOP, 2'h1, 11'h0, 1'b0, 4'h0);
    wait_n(16);
    chk_data(32'(n_rd > n0 && n_rd - n0 < 8), 32'h1);
    quiet = 1'b0;
    req(SDCI_REQ_CLOSE, 2'h0, 11'h400, 1'b0, 4'h0);
    req(SDCI_REQ_SLEEP, 2'h0, 11'h0, 1'b0, 4'h0);
    chk_data(32'(low_power), 32'h1);
    req(SDCI_REQ_OPEN, 2'h2, row, 1'b0, 4'h0);
    chk_data(32'(bank_active), 32'h0);
    req(SDCI_REQ_WAKE, 2'h0, 11'h0, 1'b0, 4'h0);
    chk_data(32'(low_power), 32'h0);
    req(SDCI_REQ_OPEN, 2'h0, row, 1'b0, 4'h0);
    req(SDCI_REQ_SLEEP, 2'h0, 11'h0, 1'b0, 4'h0);
    chk_data(32'({low_power, bank_active}), 32'h1);
    req(SDCI_REQ_WAKE, 2'h0, 11'h0, 1'b0, 4'h0);
    wait_n(20);
    chk_data(32'(exp_rd.size() + exp_wr.size()), 32'h0);
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200us;
    miscompares++;
    conclude();
  end
endmodule // test_sdram_command_interface
